// ### ptb_map.svh
`ifndef PTB_MAP_SVH
`define PTB_MAP_SVH

// Register indices on the plain register port
`define PTB_ADDR_W          3
`define PTB_DATA_W          16
`define PTB_REG_CTRL        3'h0
`define PTB_REG_COUNT       3'h1
`define PTB_REG_PERIOD      3'h2
`define PTB_REG_STATUS      3'h3
`define PTB_REG_MASK        3'h4

// Control register fields
`define PTB_CTRL_RUN        15
`define PTB_CTRL_POST_HI    7
`define PTB_CTRL_POST_LO    4
`define PTB_CTRL_PRE_HI     3
`define PTB_CTRL_PRE_LO     2
`define PTB_CTRL_MODE_HI    1
`define PTB_CTRL_MODE_LO    0

// Count register direction flag
`define PTB_COUNT_DIR       15

// Counter geometry and reset values
`define PTB_CNT_W           15
`define PTB_PRE_W           6
`define PTB_COUNT_RST       15'h0000
`define PTB_PERIOD_RST      15'h0000
`define PTB_POST_RST        4'h0
`define PTB_PRE_RST         2'h0

`endif

// ### ptb_pkg.sv
package ptb_pkg;

  typedef enum logic [1:0] {
    MODE_FREE,
    MODE_SINGLE,
    MODE_UPDOWN,
    MODE_DOUBLE
  } ptb_mode_t;

endpackage

// ### ptb_prescaler.sv
`timescale 1ns/100ps
`include "ptb_map.svh"

module ptb_prescaler
  import ptb_pkg::*;
#(
  parameter int PRE_W = `PTB_PRE_W
) (
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  input  wire logic       run_in,
  input  wire logic       clear_in,
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);

  logic [PRE_W-1:0] pre_cnt_r;
  logic [PRE_W-1:0] last;

  // Terminal count for 1:1, 1:4, 1:16, 1:64
  always_comb begin
    case (sel_in)
      2'h0:    last = PRE_W'(0);
      2'h1:    last = PRE_W'(3);
      2'h2:    last = PRE_W'(15);
      default: last = PRE_W'(63);
    endcase
  end

  assign tick_out = run_in && (pre_cnt_r == last);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || clear_in) begin
      pre_cnt_r <= '0;
    end else if (tick_out) begin
      pre_cnt_r <= '0;
    end else if (run_in) begin
      pre_cnt_r <= pre_cnt_r + PRE_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  // The new ratio is only known after the clearing write, so it is judged one cycle later
  a_pre_clear_restart: assert property (clear_in ##1 sel_in == 2'h3 |-> !tick_out)
    else $error("prescaler ticked right after a clear at 1:64");

endmodule

// ### ptb_postscaler.sv
`timescale 1ns/100ps

module ptb_postscaler
  import ptb_pkg::*;
#(
  parameter int POST_W = 4
) (
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  input  wire logic              clear_in,
  input  wire logic              bypass_in,
  input  wire logic              event_in,
  input  wire logic [POST_W-1:0] ratio_in,
  output logic                   event_out
);

  logic [POST_W-1:0] post_cnt_r;

  // Ratio field n gives one event out per n+1 in
  assign event_out = event_in && (bypass_in || post_cnt_r == ratio_in);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || clear_in) begin
      post_cnt_r <= '0;
    end else if (event_in && !bypass_in) begin
      post_cnt_r <= (post_cnt_r == ratio_in) ? '0 : post_cnt_r + POST_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  a_post_bypass_pass: assert property (bypass_in && event_in |-> event_out)
    else $error("bypassed postscaler swallowed an event");

endmodule

// ### ptb_time_base.sv
`timescale 1ns/100ps
`include "ptb_map.svh"

// How it works
// - A 15-bit counter; count register bit 15 reads direction, 1 when counting down.
// - Counter runs while the run bit is set; clearing it freezes the count.
// - Counter equal to period resets to zero or reverses on the next step.
// - Zero period stops counting and suppresses every time base event.
// - Zero active period is never reloaded while running; software disables first.
// - Two-bit mode field picks free, single-shot, up/down or double-update.
// - Events depend on the mode and a four-bit postscale field.
// - Free mode counts up, wraps to zero after match, keeps going while running.
// - Free mode raises an event at each wrap, thinned by the postscaler.
// - Single-shot counts up once, wraps to zero and clears the run bit.
// - Single-shot raises one event at its wrap; postscaler bypassed.
// - Up/down mode reverses at period; event at zero turn-around, postscaled.
// - Double-update mode raises events at zero and at period; no postscale.
// - Prescaler divides by 1, 4, 16, 64; cleared by count or control writes.
// - Four-bit postscaler 1:1 to 1:16; cleared by count or control writes.
module ptb_time_base
  import ptb_pkg::*;
#(
  parameter int CNT_W  = `PTB_CNT_W,
  parameter int DATA_W = `PTB_DATA_W,
  parameter int ADDR_W = `PTB_ADDR_W
) (
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  output logic                   irq_out,
  output logic                   count_direction_flag_out,
  output logic                   time_base_event_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic             time_base_run_r;
  ptb_mode_t        time_base_mode_select_r;
  logic [3:0]       interrupt_postscale_select_r;
  logic [1:0]       input_prescale_select_r;
  logic [CNT_W-1:0] time_base_count_r;
  logic             count_direction_flag_r;
  logic [CNT_W-1:0] period_value_r;
  logic [CNT_W-1:0] period_buf_r;
  logic             irq_status_r;
  logic             irq_mask_r;

  logic ctrl_wr;
  logic count_wr;
  logic period_wr;
  logic status_wr;
  logic mask_wr;
  logic tick;
  logic step;
  logic match;
  logic at_zero;
  logic raw_evt;
  logic post_bypass;
  logic tb_evt;
  logic update_pt;
  logic single_done;

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx, input logic w);
    wr_hit = w && (a == idx);
  endfunction

  assign ctrl_wr   = wr_hit(addr_in, `PTB_REG_CTRL, wr_in);
  assign count_wr  = wr_hit(addr_in, `PTB_REG_COUNT, wr_in);
  assign period_wr = wr_hit(addr_in, `PTB_REG_PERIOD, wr_in);
  assign status_wr = wr_hit(addr_in, `PTB_REG_STATUS, wr_in);
  assign mask_wr   = wr_hit(addr_in, `PTB_REG_MASK, wr_in);

  ////////////////////////////////////////////////////////////////////////////
  // Scalers

  ptb_prescaler #(
    .PRE_W (`PTB_PRE_W)
  ) u_pre (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .run_in     (time_base_run_r),
    .clear_in   (ctrl_wr || count_wr),
    .sel_in     (input_prescale_select_r),
    .tick_out   (tick)
  );

  // Single-shot and double-update pass every event unthinned
  assign post_bypass = (time_base_mode_select_r == MODE_SINGLE) ||
                       (time_base_mode_select_r == MODE_DOUBLE);

  ptb_postscaler #(
    .POST_W (4)
  ) u_post (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .clear_in   (ctrl_wr || count_wr),
    .bypass_in  (post_bypass),
    .event_in   (raw_evt),
    .ratio_in   (interrupt_postscale_select_r),
    .event_out  (tb_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  // A zero period freezes the counter entirely
  assign step    = time_base_run_r && tick && (period_value_r != '0) && !count_wr;
  assign match   = (time_base_count_r == period_value_r);
  assign at_zero = (time_base_count_r == '0);

  // Raw event before postscaling, per mode
  always_comb begin
    raw_evt = 1'b0;
    if (step) begin
      case (time_base_mode_select_r)
        MODE_FREE:   raw_evt = match;
        MODE_SINGLE: raw_evt = match;
        MODE_UPDOWN: raw_evt = count_direction_flag_r && at_zero;
        MODE_DOUBLE: raw_evt = (count_direction_flag_r && at_zero) || (!count_direction_flag_r && match);
        default:     raw_evt = 1'b0;
      endcase
    end
  end

  assign single_done = step && match && (time_base_mode_select_r == MODE_SINGLE);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      time_base_count_r      <= `PTB_COUNT_RST;
      count_direction_flag_r <= 1'b0;
    end else if (count_wr) begin
      time_base_count_r <= wdata_in[CNT_W-1:0];
    end else if (step) begin
      case (time_base_mode_select_r)
        MODE_FREE, MODE_SINGLE: begin
          count_direction_flag_r <= 1'b0;
          time_base_count_r      <= match ? '0 : time_base_count_r + CNT_W'(1);
        end
        default: begin
          if (!count_direction_flag_r && match) begin
            count_direction_flag_r <= 1'b1;
            time_base_count_r      <= time_base_count_r - CNT_W'(1);
          end else if (count_direction_flag_r && at_zero) begin
            count_direction_flag_r <= 1'b0;
            time_base_count_r      <= CNT_W'(1);
          end else if (count_direction_flag_r) begin
            time_base_count_r <= time_base_count_r - CNT_W'(1);
          end else begin
            time_base_count_r <= time_base_count_r + CNT_W'(1);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      time_base_run_r              <= 1'b0;
      time_base_mode_select_r      <= MODE_FREE;
      interrupt_postscale_select_r <= `PTB_POST_RST;
      input_prescale_select_r      <= `PTB_PRE_RST;
    end else if (ctrl_wr) begin
      // A software write wins over the single-shot self clear in the same cycle
      time_base_run_r              <= wdata_in[`PTB_CTRL_RUN];
      time_base_mode_select_r      <= ptb_mode_t'(wdata_in[`PTB_CTRL_MODE_HI:`PTB_CTRL_MODE_LO]);
      interrupt_postscale_select_r <= wdata_in[`PTB_CTRL_POST_HI:`PTB_CTRL_POST_LO];
      input_prescale_select_r      <= wdata_in[`PTB_CTRL_PRE_HI:`PTB_CTRL_PRE_LO];
    end else if (single_done) begin
      time_base_run_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period, double buffered

  // Loads at wrap points or while halted; never out of a zero period while running
  always_comb begin
    case (time_base_mode_select_r)
      MODE_FREE, MODE_SINGLE: update_pt = step && match;
      default:                update_pt = step && at_zero;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      period_buf_r   <= `PTB_PERIOD_RST;
      period_value_r <= `PTB_PERIOD_RST;
    end else begin
      if (period_wr) begin
        period_buf_r <= wdata_in[CNT_W-1:0];
      end
      if (!time_base_run_r || update_pt) begin
        period_value_r <= period_buf_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      irq_status_r <= 1'b0;
      irq_mask_r   <= 1'b0;
    end else begin
      // Set wins over a write-one-to-clear in the same cycle
      irq_status_r <= tb_evt || (irq_status_r && !(status_wr && wdata_in[0]));
      if (mask_wr) begin
        irq_mask_r <= wdata_in[0];
      end
    end
  end

  assign irq_out = irq_status_r && irq_mask_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read port and outputs

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        `PTB_REG_CTRL: begin
          rdata_out                                          <= '0;
          rdata_out[`PTB_CTRL_RUN]                           <= time_base_run_r;
          rdata_out[`PTB_CTRL_POST_HI:`PTB_CTRL_POST_LO]     <= interrupt_postscale_select_r;
          rdata_out[`PTB_CTRL_PRE_HI:`PTB_CTRL_PRE_LO]       <= input_prescale_select_r;
          rdata_out[`PTB_CTRL_MODE_HI:`PTB_CTRL_MODE_LO]     <= time_base_mode_select_r;
        end
        `PTB_REG_COUNT:  rdata_out <= {count_direction_flag_r, time_base_count_r};
        `PTB_REG_PERIOD: rdata_out <= {1'b0, period_buf_r};
        `PTB_REG_STATUS: rdata_out <= {15'h0000, irq_status_r};
        `PTB_REG_MASK:   rdata_out <= {15'h0000, irq_mask_r};
        default:         rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      time_base_event_out <= 1'b0;
    end else begin
      time_base_event_out <= tb_evt;
    end
  end

  assign count_direction_flag_out = count_direction_flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Armed by a scaler clear, dropped at the next raw event; outside single-shot and double-update, any ratio above 1:1 swallows that one
  logic post_first_r;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || ctrl_wr || count_wr) begin
      post_first_r <= 1'b1;
    end else if (raw_evt) begin
      post_first_r <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  a_halt_holds_count: assert property (!time_base_run_r && !count_wr |=> $stable(time_base_count_r))
    else $error("count moved while halted");
  a_zero_period_quiet: assert property (period_value_r == '0 |-> !raw_evt && !step)
    else $error("zero period still stepped or raised an event");
  a_zero_period_kept: assert property (period_value_r == '0 && time_base_run_r |=> period_value_r == '0)
    else $error("zero period reloaded while running");
  a_free_wraps_zero: assert property (step && match && time_base_mode_select_r == MODE_FREE && !ctrl_wr
                                      |=> time_base_count_r == '0 && time_base_run_r)
    else $error("free mode did not wrap to zero");
  a_single_stops: assert property (single_done && !ctrl_wr |=> !time_base_run_r && time_base_count_r == '0 [*2])
    else $error("single shot did not halt at zero");
  a_updown_turns: assert property (step && match && !count_direction_flag_r && time_base_mode_select_r[1]
                                   |=> count_direction_flag_r && time_base_count_r < period_value_r)
    else $error("up/down did not reverse at period");
  a_double_events: assert property (step && time_base_mode_select_r == MODE_DOUBLE && match && !count_direction_flag_r
                                    |-> tb_evt ##1 time_base_event_out)
    else $error("double update missed a period event");
  a_single_no_post: assert property (raw_evt && time_base_mode_select_r == MODE_SINGLE |-> tb_evt)
    else $error("single shot event was postscaled");
  a_free_uses_post: assert property (raw_evt && post_first_r && time_base_mode_select_r == MODE_FREE
                                     && interrupt_postscale_select_r != 4'h0 |-> !tb_evt)
    else $error("postscaler passed the first event after a clear");
  a_irq_follows: assert property (tb_evt && irq_mask_r && !mask_wr |=> irq_out)
    else $error("masked-in event did not raise the interrupt");

  c_free_wrap:   cover property (step && match && time_base_mode_select_r == MODE_FREE);
  c_single_done: cover property (single_done ##1 !time_base_run_r);
  c_updown_turn: cover property (raw_evt && time_base_mode_select_r == MODE_UPDOWN);
  c_irq:         cover property (irq_out);

endmodule

// ### tb.sv
`timescale 1ns/100ps
`include "ptb_map.svh"

module tb;
  import ptb_pkg::*;

  logic        ref_clk_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic [2:0]  addr_in    = 3'h0;
  logic [15:0] wdata_in   = 16'h0000;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic [15:0] rdata_out;
  logic        irq_out;
  logic        count_direction_flag_out;
  logic        time_base_event_out;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  int          ev_cnt     = 0;
  int          last_ev    = 0;
  int          gap        = 0;
  logic [15:0] d;
  logic [15:0] d1;
  int          e0;

  ptb_time_base ptb_time_base_i (
    .ref_clk_in               (ref_clk_in),
    .srst_in                  (srst_in),
    .addr_in                  (addr_in),
    .wdata_in                 (wdata_in),
    .wr_in                    (wr_in),
    .rd_in                    (rd_in),
    .rdata_out                (rdata_out),
    .irq_out                  (irq_out),
    .count_direction_flag_out (count_direction_flag_out),
    .time_base_event_out      (time_base_event_out)
  );

  always #25 ref_clk_in = ~ref_clk_in;

  // Event monitor: spacing between event pulses is what the modes promise
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (!srst_in && time_base_event_out === 1'b1) begin
      ev_cnt  <= ev_cnt + 1;
      gap     <= cyc - last_ev;
      last_ev <= cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    @(negedge ref_clk_in);
    v = rdata_out;
  endtask

  // Halt first so the active period reloads and no stale event mixes in
  task automatic cfg(input logic [1:0] m, input logic [1:0] s, input logic [3:0] p, input logic [14:0] per);
    wr(`PTB_REG_CTRL, 16'h0000);
    wr(`PTB_REG_PERIOD, {1'b0, per});
    wr(`PTB_REG_COUNT, 16'h0000);
    wr(`PTB_REG_CTRL, {1'b1, 7'h00, p, s, m});
  endtask

  // The second event's spacing is fully inside the new setting
  task automatic gap_chk(input int exp);
    int target;
    target = ev_cnt + 2;
    for (int i = 0; i < 4000 && ev_cnt < target; i++) begin
      @(posedge ref_clk_in);
    end
    @(negedge ref_clk_in);
    chk("event arrived", 16'(ev_cnt >= target), 16'h0001);
    chk("event gap", 16'(gap), 16'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    n_mismatch++;
    $display("unexpected watchdog expiry: tests did not finish in time");
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      rd(3'(a), d);
      chk("register after reset", d, 16'h0000);
    end
    // Zero period: nothing counts, nothing fires, new period waits in the buffer
    wr(`PTB_REG_CTRL, 16'h8000);
    repeat (30) @(posedge ref_clk_in);
    rd(`PTB_REG_COUNT, d);
    chk("count with zero period", d, 16'h0000);
    chk("events with zero period", 16'(ev_cnt), 16'h0000);
    wr(`PTB_REG_PERIOD, 16'h0005);
    repeat (30) @(posedge ref_clk_in);
    rd(`PTB_REG_COUNT, d);
    chk("count after period write", d, 16'h0000);
    rd(`PTB_REG_PERIOD, d);
    chk("period buffer", d, 16'h0005);
    chk("irq idle", {15'h0000, irq_out}, 16'h0000);
    // Free running: period match wraps, every prescale ratio
    cfg(MODE_FREE, 2'h0, 4'h0, 15'h0001);
    gap_chk(2);
    for (int s = 0; s < 4; s++) begin
      cfg(MODE_FREE, 2'(s), 4'h0, 15'h0003);
      gap_chk(4 << (2 * s));
    end
    cfg(MODE_FREE, 2'h0, 4'h3, 15'h0003);
    gap_chk(16);
    cfg(MODE_FREE, 2'h0, 4'hf, 15'h0000 + 15'h0001);
    gap_chk(32);
    // Interrupt: sticky status, mask, write-one-to-clear
    wr(`PTB_REG_CTRL, 16'h0000);
    repeat (5) @(posedge ref_clk_in);
    rd(`PTB_REG_STATUS, d);
    chk("status after events", d & 16'h0001, 16'h0001);
    chk("irq while masked", {15'h0000, irq_out}, 16'h0000);
    wr(`PTB_REG_MASK, 16'h0001);
    @(negedge ref_clk_in);
    chk("irq unmasked", {15'h0000, irq_out}, 16'h0001);
    wr(`PTB_REG_STATUS, 16'h0000);
    @(negedge ref_clk_in);
    chk("irq after zero write", {15'h0000, irq_out}, 16'h0001);
    wr(`PTB_REG_STATUS, 16'h0001);
    @(negedge ref_clk_in);
    chk("irq after clear", {15'h0000, irq_out}, 16'h0000);
    rd(`PTB_REG_STATUS, d);
    chk("status after clear", d & 16'h0001, 16'h0000);
    // Single shot: one event, run bit cleared, postscaler ignored
    cfg(MODE_SINGLE, 2'h0, 4'h3, 15'h0005);
    e0 = ev_cnt;
    repeat (40) @(posedge ref_clk_in);
    chk("single shot events", 16'(ev_cnt - e0), 16'h0001);
    chk("irq after single shot", {15'h0000, irq_out}, 16'h0001);
    rd(`PTB_REG_CTRL, d);
    chk("run bit after shot", {15'h0000, d[15]}, 16'h0000);
    rd(`PTB_REG_COUNT, d);
    chk("count after shot", d, 16'h0000);
    wr(`PTB_REG_MASK, 16'h0000);
    // Count write and control write against the prescaler
    cfg(MODE_FREE, 2'h2, 4'h0, 15'h0064);
    wr(`PTB_REG_COUNT, 16'h0032);
    rd(`PTB_REG_COUNT, d);
    chk("count after write", d, 16'h0032);
    wr(`PTB_REG_CTRL, 16'h0008);
    rd(`PTB_REG_COUNT, d1);
    chk("direction in free mode", {15'h0000, d1[15]}, 16'h0000);
    repeat (40) @(posedge ref_clk_in);
    rd(`PTB_REG_COUNT, d);
    chk("count frozen when halted", d, d1);
    wr(`PTB_REG_CTRL, 16'h8008);
    rd(`PTB_REG_COUNT, d);
    chk("count kept over control write", d, d1);
    // Up/down and double update
    cfg(MODE_UPDOWN, 2'h0, 4'h0, 15'h0004);
    gap_chk(8);
    cfg(MODE_UPDOWN, 2'h0, 4'h1, 15'h0004);
    gap_chk(16);
    cfg(MODE_DOUBLE, 2'h0, 4'h3, 15'h0004);
    gap_chk(4);
    gap_chk(4);
    cfg(MODE_UPDOWN, 2'h0, 4'h0, 15'h0064);
    for (int i = 0; i < 300 && count_direction_flag_out !== 1'b1; i++) begin
      @(posedge ref_clk_in);
    end
    chk("direction output down", {15'h0000, count_direction_flag_out}, 16'h0001);
    rd(`PTB_REG_COUNT, d);
    chk("direction bit down", {15'h0000, d[15]}, 16'h0001);
    give_verdict();
  end

endmodule
